/* verilog/rsps_strap_select.sv */
/*
  Strap capture and shared pad ownership decode.
  Assumes the straps are board resistors, stable while rst_n is low, and that
  the register port comes from logic on clk.
*/
`timescale 1ns/10ps
module rsps_strap_select
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pci_select_strap,
  input  wire logic        ethernet_select_strap,
  input  wire logic        host_width_strap,
  input  wire logic        eeprom_autoinit_strap,
  input  wire logic        reserved_low_strap,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic      [31:0] peripheral_config,
  output logic      [31:0] strap_status,
  output logic             host_port_en,
  output logic             host_port_32bit,
  output logic             host_port_16bit,
  output logic             pci_en,
  output logic             pci_eeprom_load,
  output logic             ethernet_ethernet_select_strap,
  output logic             upper_gpio_group_en,
  output logic             lower_gpio_group_en,
  output logic             timers_i2c_en,
  output logic      [1:0]  host_lower_data_pads_owner,
  output logic      [1:0]  host_upper_data_pads_owner,
  output logic             pci_only_pads_oe,
  output logic             invalid_strap
);

  //////////////////////////////////////////////////////////////////////////
  // Strap synchronisers. Straps come from pads, so two flops first.

  logic [4:0] sync1_q, sync1_d;
  logic [4:0] sync2_q, sync2_d;

  always_comb
  begin
    sync1_d = {reserved_low_strap, eeprom_autoinit_strap, host_width_strap,
               ethernet_select_strap, pci_select_strap};
    sync2_d = sync1_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Capture. The async reset cannot load a pin, so the straps are taken on
  // the first edge after release once the synchroniser has filled; the pads
  // stay off until then, except the lower GPIO group and timers/I2C enables, which are always on.

  logic [1:0] fill_q, fill_d;
  logic       cap_q, cap_d;
  logic [4:0] strap_q, strap_d;

  always_comb
  begin
    fill_d  = fill_q;
    cap_d   = cap_q;
    strap_d = strap_q;
    if (fill_q != 2'h2)
    begin
      fill_d = fill_q + 2'h1;
    end
    else if (!cap_q)
    begin
      strap_d = sync2_q;
      cap_d   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fill_q  <= 2'h0;
      cap_q   <= 1'b0;
      strap_q <= 5'h00;
    end
    else
    begin
      fill_q  <= fill_d;
      cap_q   <= cap_d;
      strap_q <= strap_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software configuration register, writable once the straps are captured.

  logic [31:0] cfg_q, cfg_d;
  logic        hit;

  always_comb
  begin
    hit   = (cfg_addr == rsps_pkg::PERIPHERAL_CONFIG_OFFSET);
    cfg_d = cfg_q;
    if (cfg_wr && hit && cap_q)
    begin
      cfg_d = cfg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= rsps_pkg::PERIPHERAL_CONFIG_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decode of the held straps into pad ownership.

  logic pci, eth, wide, eep, bad;
  logic [31:0] st;

  always_comb
  begin
    pci  = strap_q[0];
    eth  = strap_q[1];
    wide = strap_q[2];
    eep  = strap_q[3];
    bad  = strap_q[4] && cap_q;
    host_port_en        = cap_q && !pci && !(eth && wide);
    host_port_32bit     = host_port_en && wide && !eth;
    host_port_16bit     = host_port_en && !wide;
    pci_en              = cap_q && pci;
    pci_eeprom_load     = pci_en && eep;
    ethernet_ethernet_select_strap     = cap_q && !pci && eth;
    upper_gpio_group_en = cap_q && !pci;
    lower_gpio_group_en = 1'b1;
    timers_i2c_en       = 1'b1;
    pci_only_pads_oe    = pci_en;
    // One owner per pad group, so users can never collide.
    host_lower_data_pads_owner = rsps_pkg::RSPS_OWN_OFF;
    host_upper_data_pads_owner = rsps_pkg::RSPS_OWN_OFF;
    if (pci_en)
    begin
      host_lower_data_pads_owner = rsps_pkg::RSPS_OWN_PCI;
      host_upper_data_pads_owner = rsps_pkg::RSPS_OWN_PCI;
    end
    else if (cap_q)
    begin
      if (host_port_en)
      begin
        host_lower_data_pads_owner = rsps_pkg::RSPS_OWN_HOST;
      end
      if (ethernet_ethernet_select_strap)
      begin
        host_upper_data_pads_owner = rsps_pkg::RSPS_OWN_ETH;
      end
      else if (host_port_32bit)
      begin
        host_upper_data_pads_owner = rsps_pkg::RSPS_OWN_HOST;
      end
    end
    st = 32'h0000_0000;
    st[rsps_pkg::ST_PCI_SEL]   = pci;
    st[rsps_pkg::ST_ETH_SEL]   = eth;
    st[rsps_pkg::ST_HOST_WIDE] = wide;
    st[rsps_pkg::ST_EEPROM]    = eep;
    st[rsps_pkg::ST_BAD_STRAP] = bad;
    st[rsps_pkg::ST_CAPTURED]  = cap_q;
  end

  assign invalid_strap     = bad;
  assign peripheral_config = cfg_q;
  assign strap_status      = st;

  //////////////////////////////////////////////////////////////////////////
  // Read port, registered data.

  logic [31:0] rd_q, rd_d;

  always_comb
  begin
    rd_d = rd_q;
    if (cfg_rd)
    begin
      rd_d = hit ? cfg_q : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      rd_q <= rd_d;
    end
  end

  assign cfg_rdata = rd_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_hold;
    @(posedge clk) disable iff (!rst_n) $past(cap_q) |-> $stable(strap_q);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed after capture");

  property p_capture;
    @(posedge clk) disable iff (!rst_n) (fill_q == 2'h2 && !cap_q) |=> (cap_q && strap_q == $past(sync2_q));
  endproperty
  a_capture: assert property (p_capture) else $error("strap not captured");

  property p_pci_host;
    @(posedge clk) disable iff (!rst_n) pci_en |-> (!host_port_en && !ethernet_ethernet_select_strap && !upper_gpio_group_en);
  endproperty
  a_pci_host: assert property (p_pci_host) else $error("pci mode left other users on");

  property p_eth;
    @(posedge clk) disable iff (!rst_n) ethernet_ethernet_select_strap == (cap_q && !strap_q[0] && strap_q[1]);
  endproperty
  a_eth: assert property (p_eth) else $error("ethernet enable wrong");

  property p_eeprom;
    @(posedge clk) disable iff (!rst_n) pci_eeprom_load |-> (pci_en && strap_q[3]);
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom load wrong");

  property p_upper;
    @(posedge clk) disable iff (!rst_n)
      (cap_q && !strap_q[0] && !strap_q[1] && !strap_q[2]) |-> host_upper_data_pads_owner == rsps_pkg::RSPS_OWN_OFF;
  endproperty
  a_upper: assert property (p_upper) else $error("upper pads not off in 16-bit");

  property p_eth_wide;
    @(posedge clk) disable iff (!rst_n) (cap_q && !strap_q[0] && strap_q[1] && strap_q[2]) |-> !host_port_en;
  endproperty
  a_eth_wide: assert property (p_eth_wide) else $error("host on with ethernet wide");

  property p_precap;
    @(posedge clk) disable iff (!rst_n) !cap_q |-> (!host_port_en && !pci_en && !pci_only_pads_oe);
  endproperty
  a_precap: assert property (p_precap) else $error("pads driven before capture");

  property p_no_eeprom;
    @(posedge clk) disable iff (!rst_n) (pci_en && !strap_q[3]) |-> !pci_eeprom_load;
  endproperty
  a_no_eeprom: assert property (p_no_eeprom) else $error("eeprom load with strap low");

  property p_pci_pads;
    @(posedge clk) disable iff (!rst_n)
      pci_en |-> (pci_only_pads_oe && host_lower_data_pads_owner == rsps_pkg::RSPS_OWN_PCI
                  && host_upper_data_pads_owner == rsps_pkg::RSPS_OWN_PCI);
  endproperty
  a_pci_pads: assert property (p_pci_pads) else $error("pci mode pads not owned by pci");

  property p_host_pads;
    @(posedge clk) disable iff (!rst_n)
      (cap_q && !strap_q[0]) |-> (!pci_only_pads_oe && host_lower_data_pads_owner != rsps_pkg::RSPS_OWN_PCI
                                  && host_upper_data_pads_owner != rsps_pkg::RSPS_OWN_PCI);
  endproperty
  a_host_pads: assert property (p_host_pads) else $error("pci pads driven with pci off");

  c_pci:  cover property (@(posedge clk) disable iff (!rst_n) pci_eeprom_load);
  c_eth:  cover property (@(posedge clk) disable iff (!rst_n) ethernet_ethernet_select_strap && host_port_16bit);
  c_wide: cover property (@(posedge clk) disable iff (!rst_n) host_port_32bit);
  c_pci_plain: cover property (@(posedge clk) disable iff (!rst_n) pci_en && !pci_eeprom_load);
  c_bad:  cover property (@(posedge clk) disable iff (!rst_n) invalid_strap);

endmodule : rsps_strap_select

/* verilog/rsps_pkg.sv */
/*
  Package for the reset strap peripheral select block: register offset,
  strap field positions, reset values and the selection encodings.
  Assumes nothing of its surroundings.
*/
package rsps_pkg;

  localparam logic [31:0] PERIPHERAL_CONFIG_OFFSET = 32'h01b3f000;
  localparam logic [31:0] PERIPHERAL_CONFIG_RESET  = 32'h0000_0000;

  // Field positions of the read-back status word.
  localparam int ST_PCI_SEL   = 0;
  localparam int ST_ETH_SEL   = 1;
  localparam int ST_HOST_WIDE = 2;
  localparam int ST_EEPROM    = 3;
  localparam int ST_BAD_STRAP = 4;
  localparam int ST_CAPTURED  = 5;
  localparam int ST_WIDTH     = 6;

  // Pad owner encoding for the shared host data pads.
  typedef enum logic [1:0]
  {
    RSPS_OWN_OFF  = 2'b00,
    RSPS_OWN_HOST = 2'b01,
    RSPS_OWN_ETH  = 2'b10,
    RSPS_OWN_PCI  = 2'b11
  } rsps_owner_e;

endpackage : rsps_pkg

/* verification/rsps_board_straps.sv */
/*
  Board strap resistor model for the strap select bench.
  Assumes the bench picks the fitted resistors between device resets.
*/
`timescale 1ns/10ps
module rsps_board_straps
(
  input  wire logic [4:0] fit,
  output logic            pci_select_strap,
  output logic            ethernet_select_strap,
  output logic            host_width_strap,
  output logic            eeprom_autoinit_strap,
  output logic            reserved_low_strap
);
  // Resistors drive no edges, so the fitted levels stand until the bench refits.
  // The reserved strap only goes high when a scenario fits the illegal pull-up.
  assign {reserved_low_strap, eeprom_autoinit_strap, host_width_strap,
          ethernet_select_strap, pci_select_strap} = fit;
endmodule : rsps_board_straps

/* verification/tb_reset_strap_peripheral_select.sv */
/*
  Self-checking bench for the strap select block.
  Assumes the board model drives the straps and the bench owns reset and the register port.
*/
`timescale 1ns/10ps
module tb_reset_strap_peripheral_select;
  logic        clk, rst_n, cfg_wr, cfg_rd;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, peripheral_config, strap_status;
  logic [4:0]  fit;
  logic        ps, es, ws, ees, rs;
  logic        hpe, h32, h16, pci, eel, mac, ugp, lgp, tim, oe, inv;
  logic [1:0]  lo, up;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  wire logic [14:0] dec = {hpe, h32, h16, pci, eel, mac, ugp, lgp, tim, lo, up, oe, inv};
  localparam logic [31:0] OFS = rsps_pkg::PERIPHERAL_CONFIG_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  rsps_board_straps board
  (
    .fit(fit), .pci_select_strap(ps), .ethernet_select_strap(es),
    .host_width_strap(ws), .eeprom_autoinit_strap(ees), .reserved_low_strap(rs)
  );
  rsps_strap_select uut
  (
    .clk(clk), .rst_n(rst_n), .pci_select_strap(ps), .ethernet_select_strap(es),
    .host_width_strap(ws), .eeprom_autoinit_strap(ees), .reserved_low_strap(rs),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .peripheral_config(peripheral_config), .strap_status(strap_status),
    .host_port_en(hpe), .host_port_32bit(h32), .host_port_16bit(h16), .pci_en(pci),
    .pci_eeprom_load(eel), .ethernet_ethernet_select_strap(mac), .upper_gpio_group_en(ugp),
    .lower_gpio_group_en(lgp), .timers_i2c_en(tim), .host_lower_data_pads_owner(lo),
    .host_upper_data_pads_owner(up), .pci_only_pads_oe(oe), .invalid_strap(inv)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The run is about 400 cycles; the ceiling leaves a wide margin.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic rst_pulse;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask : rst_pulse

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(negedge clk);
  endtask : rd

  function automatic logic [14:0] exp_dec(input logic [4:0] s);
    logic       p, e, w;
    logic [1:0] lo_e, up_e;
    p    = s[0];
    e    = s[1];
    w    = s[2];
    lo_e = p ? rsps_pkg::RSPS_OWN_PCI : (e && w) ? rsps_pkg::RSPS_OWN_OFF : rsps_pkg::RSPS_OWN_HOST;
    up_e = p ? rsps_pkg::RSPS_OWN_PCI : e ? rsps_pkg::RSPS_OWN_ETH :
           w ? rsps_pkg::RSPS_OWN_HOST : rsps_pkg::RSPS_OWN_OFF;
    return {!p && !(e && w), !p && !e && w, !p && !w, p, p && s[3], !p && e, !p, 2'b11, lo_e, up_e, p, s[4]};
  endfunction : exp_dec

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n     = 1'b0;
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 32'h0;
    cfg_wdata = 32'h0;
    fit       = 5'h00;
    // Every strap combination, each captured by its own reset.
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      fit <= i[4:0];
      rst_pulse();
      @(negedge clk);
      check("before_capture", 32'(dec), 32'h00c0);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("decode", 32'(dec), 32'(exp_dec(i[4:0])));
      check("eeprom_width", 32'(dec), 32'(exp_dec(i[4:0])));
      check("status", strap_status, {26'h0, 1'b1, i[4:0]});
      @(posedge clk);
      fit <= ~i[4:0];
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("hold", 32'(dec), 32'(exp_dec(i[4:0])));
    end
    check("cfg_reset", peripheral_config, rsps_pkg::PERIPHERAL_CONFIG_RESET);
    wr(OFS, 32'ha5c3_0f96);
    check("cfg_write", peripheral_config, 32'ha5c3_0f96);
    rd(OFS);
    check("cfg_read", cfg_rdata, 32'ha5c3_0f96);
    wr(OFS + 32'h4, 32'h1234_5678);
    check("cfg_unmapped_wr", peripheral_config, 32'ha5c3_0f96);
    rd(OFS + 32'h4);
    check("cfg_unmapped_rd", cfg_rdata, 32'h0);
    // A write landing before the straps are captured must be dropped.
    rst_pulse();
    wr(OFS, 32'hffff_ffff);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("cfg_precapture", peripheral_config, rsps_pkg::PERIPHERAL_CONFIG_RESET);
    close_out();
  end
endmodule : tb_reset_strap_peripheral_select
